/* hdl/pgs_map.svh */
`ifndef PGS_MAP_SVH
`define PGS_MAP_SVH

// clock and time base
`define PGS_CLK_PERIOD_NS 10
`define PGS_NS_PER_US 1000
`define PGS_US_CYCLES (`PGS_NS_PER_US / `PGS_CLK_PERIOD_NS)
`define PGS_US_PER_MS 1000

// supervisor times, in microseconds unless named otherwise
`define PGS_UV_FALL_RELAX_US 1000
`define PGS_UV_FALL_SUPERVISION_A_US 50
`define PGS_UV_RISE_US 10
`define PGS_OV_RISE_US 50
`define PGS_OV_FALL_US 1000
`define PGS_BLANK_MS 5
`define PGS_BLANK_US (`PGS_BLANK_MS * `PGS_US_PER_MS)

// register byte offsets
`define PGS_REG_CTRL 4'h0
`define PGS_REG_ENABLE 4'h4
`define PGS_REG_SWCFG 4'h8
`define PGS_REG_FLAGS 4'hC

// control fields
`define PGS_CTRL_SUPERVISION_A 0
`define PGS_CTRL_DLY_LSB 8
`define PGS_CTRL_DLY_MSB 15
`define PGS_CTRL_RESET 32'h0000_0000

// enable fields
`define PGS_EN_RAIL_LSB 0
`define PGS_EN_RAIL_MSB 4
`define PGS_EN_SW_LSB 5
`define PGS_EN_SW_MSB 7

// switch configuration fields
`define PGS_SW_DCHG_LSB 0
`define PGS_SW_DCHG_MSB 2
`define PGS_SW_SHED_LSB 3
`define PGS_SW_SHED_MSB 5
`define PGS_SW_LIM2_LSB 6
`define PGS_SW_LIM2_MSB 7
`define PGS_SW_LIM3_LSB 8
`define PGS_SW_LIM3_MSB 9

// flag and status fields
`define PGS_FL_ILIM_LSB 0
`define PGS_FL_ILIM_MSB 2
`define PGS_FL_FAULT_LSB 3
`define PGS_FL_FAULT_MSB 5
`define PGS_ST_PG 8
`define PGS_ST_BU 9
`define PGS_ST_RAIL_LSB 16
`define PGS_ST_RAIL_MSB 20
`define PGS_ST_PIN 24

`endif

/* hdl/pgs_pkg.sv */
package pgs_pkg;
	localparam int PGS_RAILS = 5;
	localparam int PGS_SWITCHES = 3;
	typedef logic [PGS_RAILS-1:0] pgs_rail_t;
	typedef logic [PGS_SWITCHES-1:0] pgs_sw_t;
	typedef logic [1:0] pgs_lim_t;
	typedef logic [9:0] pgs_us_t;
	typedef logic [12:0] pgs_blank_t;
	typedef enum logic [1:0] {
		PGS_OFF,
		PGS_WAIT,
		PGS_GOOD,
		PGS_FAULT
	} pgs_state_t;
endpackage

/* hdl/pgs_if.sv */
`timescale 1ns/1ps
interface pgs_mon_if;
	logic tick_us;
	logic supervision_a;
	logic enable;
	logic uv;
	logic ov;
	logic fault;
	modport mon(input tick_us, input supervision_a, input enable, input uv, input ov, output fault);
	modport ctl(output tick_us, output supervision_a, output enable, output uv, output ov, input fault);
endinterface

interface pgs_sw_if;
	logic enable;
	logic dchg_cfg;
	logic over_temperature_shutdown;
	logic in_uv;
	logic ilim;
	logic on;
	logic discharge;
	logic fault;
	logic limiting;
	modport sw(input enable, input dchg_cfg, input over_temperature_shutdown, input in_uv, input ilim,
		output on, output discharge, output fault, output limiting);
	modport ctl(output enable, output dchg_cfg, output over_temperature_shutdown, output in_uv, output ilim,
		input on, input discharge, input fault, input limiting);
endinterface

/* hdl/pgs_rail_mon.sv */
`timescale 1ns/1ps
module pgs_rail_mon #(
	parameter pgs_pkg::pgs_blank_t BLANK_US = 13'h1388,
	parameter pgs_pkg::pgs_us_t UV_RELAX_US = 10'h3E8,
	parameter pgs_pkg::pgs_us_t UV_SUPERVISION_A_US = 10'h032,
	parameter pgs_pkg::pgs_us_t UV_RISE_US = 10'h00A,
	parameter pgs_pkg::pgs_us_t OV_RISE_US = 10'h032,
	parameter pgs_pkg::pgs_us_t OV_FALL_US = 10'h3E8
) (
	input wire logic clk,
	input wire logic rst_b,
	pgs_mon_if.mon mif
);
	import pgs_pkg::*;

	pgs_blank_t blank_r;
	logic armed_r;
	pgs_us_t dg_r;
	logic bad_r;
	logic ov_cause_r;
	logic raw_bad;
	pgs_us_t lim;

	// relaxed mode looks at undervoltage only
	assign raw_bad = mif.uv | (mif.supervision_a & mif.ov);

	always_comb begin
		if (bad_r) begin
			lim = ov_cause_r ? OV_FALL_US : UV_RISE_US;
		end else if (mif.uv) begin
			lim = mif.supervision_a ? UV_SUPERVISION_A_US : UV_RELAX_US;
		end else begin
			lim = OV_RISE_US;
		end
	end

	// start-up blanking lets the rail ramp before it is judged
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			blank_r <= '0;
			armed_r <= 1'b0;
		end else if (!mif.enable) begin
			blank_r <= '0;
			armed_r <= 1'b0;
		end else if (mif.tick_us && !armed_r) begin
			if (blank_r >= BLANK_US - 13'h0001) begin
				armed_r <= 1'b1;
			end else begin
				blank_r <= blank_r + 13'h0001;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dg_r <= '0;
			bad_r <= 1'b0;
			ov_cause_r <= 1'b0;
		end else if (!mif.enable || !armed_r) begin
			dg_r <= '0;
			bad_r <= 1'b0;
			ov_cause_r <= 1'b0;
		end else if (raw_bad == bad_r) begin
			dg_r <= '0;
		end else if (mif.tick_us) begin
			if (dg_r >= lim - 10'h001) begin
				dg_r <= '0;
				bad_r <= raw_bad;
				ov_cause_r <= raw_bad & ~mif.uv;
			end else begin
				dg_r <= dg_r + 10'h001;
			end
		end
	end

	assign mif.fault = bad_r;
endmodule

/* hdl/pgs_switch.sv */
`timescale 1ns/1ps
module pgs_switch (
	input wire logic clk,
	input wire logic rst_b,
	pgs_sw_if.sw sif
);
	import pgs_pkg::*;

	logic on_r;
	logic dchg_r;
	logic fault_r;
	logic lim_r;
	logic held_off;

	// thermal or input-undervoltage hold-off, released by hardware alone
	assign held_off = sif.over_temperature_shutdown | sif.in_uv;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			on_r <= 1'b0;
			dchg_r <= 1'b0;
			fault_r <= 1'b0;
			lim_r <= 1'b0;
		end else begin
			on_r <= sif.enable & ~held_off;
			dchg_r <= sif.dchg_cfg & ~(sif.enable & ~held_off);
			fault_r <= sif.enable & held_off;
			lim_r <= sif.enable & ~held_off & sif.ilim;
		end
	end

	assign sif.on = on_r;
	assign sif.discharge = dchg_r;
	assign sif.fault = fault_r;
	assign sif.limiting = lim_r;
endmodule

/* hdl/pgs_top.sv */
`timescale 1ns/1ps
`include "pgs_map.svh"
// Notes on behaviour
// - power-good released only when enabled rails good
// - relaxed: undervoltage only, long fall deglitch
// - supervision_a: tighter undervoltage, short fall deglitch
// - supervision_a also watches overvoltage
// - power-good low after reset, all-off
// - disabled rails are ignored
// - rail judged 5 ms after enable
// - programmed delay after sequencer done
// - deglitched fault drops power-good, starts power-down
// - disabling a rail only matters if last
// - power-down and suspend force power-good low
// - backup power-good is AND of two
// - backup fault touches nothing else
// - supply failure starts power-down; reset shuts all
// - switches follow enable; sequencer drives first
// - per-switch discharge when off, if enabled
// - power-fail sheds chosen switches until rewritten
// - current limiting raises flag, switch stays on
// - overtemperature holds switch off with fault
// - second switch has two-bit limit select
// - second switch input undervoltage holds off
// - third switch has two-bit limit select
module pgs_top #(
	parameter pgs_pkg::pgs_blank_t BLANK_US = 13'(`PGS_BLANK_US),
	parameter pgs_pkg::pgs_us_t UV_RELAX_US = 10'(`PGS_UV_FALL_RELAX_US),
	parameter pgs_pkg::pgs_us_t OV_FALL_US = 10'(`PGS_OV_FALL_US),
	parameter logic [9:0] MS_TICKS = 10'(`PGS_US_PER_MS)
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire pgs_pkg::pgs_rail_t rail_uv,
	input wire pgs_pkg::pgs_rail_t rail_ov,
	input wire logic [1:0] backup_rail_good,
	input wire logic power_fail_input,
	input wire logic undervoltage_lockout,
	input wire pgs_pkg::pgs_sw_t switch_ilim,
	input wire pgs_pkg::pgs_sw_t switch_ots,
	input wire logic switch2_input_uv,
	input wire logic seq_done,
	input wire logic seq_powerdown,
	input wire logic suspend,
	input wire pgs_pkg::pgs_rail_t seq_rail_set,
	input wire pgs_pkg::pgs_rail_t seq_rail_clr,
	input wire logic seq_switch1_set,
	input wire logic seq_switch1_clr,
	input wire logic main_power_good_i,
	output logic main_power_good_o,
	output logic main_power_good_oe,
	output logic backup_power_good,
	output logic powerdown_trigger,
	output pgs_pkg::pgs_rail_t rail_enable,
	output pgs_pkg::pgs_rail_t rail_discharge,
	output pgs_pkg::pgs_sw_t switch_enable,
	output pgs_pkg::pgs_sw_t switch_discharge_enable,
	output pgs_pkg::pgs_lim_t switch2_limit_select,
	output pgs_pkg::pgs_lim_t switch3_limit_select
);
	import pgs_pkg::*;

	localparam int SYNC_W = 22;
	localparam logic [6:0] US_DIV = 7'(`PGS_US_CYCLES);
	localparam logic [16:0] MS_CYCLES = 17'(MS_TICKS) * 17'(US_DIV);

	logic [SYNC_W-1:0] sync1_r;
	logic [SYNC_W-1:0] sync2_r;
	pgs_rail_t uv_s;
	pgs_rail_t ov_s;
	logic [1:0] bu_s;
	logic pf_s;
	logic undervoltage_lockout_s;
	pgs_sw_t ilim_s;
	pgs_sw_t ots_s;
	logic sw2uv_s;
	logic pin_s;

	logic [6:0] us_cnt_r;
	logic tick_us_r;
	logic [16:0] ms_cnt_r;
	logic tick_ms_r;

	logic [31:0] ctrl_r;
	pgs_rail_t rail_en_r;
	pgs_sw_t sw_en_r;
	logic [9:0] swcfg_r;
	logic [5:0] flags_r;
	logic [5:0] flags_nxt;
	logic pf_d_r;
	logic undervoltage_lockout_d_r;
	logic pf_trip;

	pgs_state_t state_r;
	pgs_state_t state_nxt;
	logic [7:0] dly_r;
	logic any_en;
	logic any_fault;
	logic abort;
	logic pg_oe_r;
	logic bu_r;
	logic pd_r;
	pgs_rail_t rail_dchg_r;

	logic wait_r;
	logic [31:0] rdata_r;
	logic bus_req;
	logic bus_wr;
	logic [31:0] rd_mux;

	pgs_rail_t mon_fault;
	pgs_sw_t sw_on;
	pgs_sw_t sw_dchg;
	pgs_sw_t sw_fault;
	pgs_sw_t sw_lim;

	// every pin from the analog side is brought into the clock domain first
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= {rail_uv, rail_ov, backup_rail_good, power_fail_input, undervoltage_lockout,
				switch_ilim, switch_ots, switch2_input_uv, main_power_good_i};
			sync2_r <= sync1_r;
		end
	end

	assign {uv_s, ov_s, bu_s, pf_s, undervoltage_lockout_s, ilim_s, ots_s, sw2uv_s, pin_s} = sync2_r;

	// microsecond enable for the rail monitors; the delay divider counts clocks itself
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			us_cnt_r <= '0;
			tick_us_r <= 1'b0;
		end else if (us_cnt_r >= US_DIV - 7'h01) begin
			us_cnt_r <= '0;
			tick_us_r <= 1'b1;
		end else begin
			us_cnt_r <= us_cnt_r + 7'h01;
			tick_us_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ms_cnt_r <= '0;
			tick_ms_r <= 1'b0;
		end else if (state_r != PGS_WAIT) begin // restart on entry so a delay is never cut short
			ms_cnt_r <= '0;
			tick_ms_r <= 1'b0;
		end else if (ms_cnt_r >= MS_CYCLES - 17'h00001) begin
			ms_cnt_r <= '0;
			tick_ms_r <= 1'b1;
		end else begin
			ms_cnt_r <= ms_cnt_r + 17'h00001;
			tick_ms_r <= 1'b0;
		end
	end

	// per-rail monitors
	genvar gi;
	generate
		for (gi = 0; gi < PGS_RAILS; gi++) begin : g_rail
			pgs_mon_if mif();
			assign mif.tick_us = tick_us_r;
			assign mif.supervision_a = ctrl_r[`PGS_CTRL_SUPERVISION_A];
			assign mif.enable = rail_en_r[gi];
			assign mif.uv = uv_s[gi];
			assign mif.ov = ov_s[gi];
			assign mon_fault[gi] = mif.fault;
			// first two converters use the tighter window thresholds in the analog comparators
			pgs_rail_mon #(
				.BLANK_US(BLANK_US),
				.UV_RELAX_US(UV_RELAX_US),
				.UV_SUPERVISION_A_US(10'(`PGS_UV_FALL_SUPERVISION_A_US)),
				.UV_RISE_US(10'(`PGS_UV_RISE_US)),
				.OV_RISE_US(10'(`PGS_OV_RISE_US)),
				.OV_FALL_US(OV_FALL_US)
			) u_mon (
				.clk(clk),
				.rst_b(rst_b),
				.mif(mif)
			);
		end
		for (gi = 0; gi < PGS_SWITCHES; gi++) begin : g_sw
			pgs_sw_if sif();
			assign sif.enable = sw_en_r[gi];
			assign sif.dchg_cfg = swcfg_r[`PGS_SW_DCHG_LSB + gi];
			assign sif.over_temperature_shutdown = ots_s[gi];
			assign sif.in_uv = (gi == 1) ? sw2uv_s : 1'b0;
			assign sif.ilim = ilim_s[gi];
			assign sw_on[gi] = sif.on;
			assign sw_dchg[gi] = sif.discharge;
			assign sw_fault[gi] = sif.fault;
			assign sw_lim[gi] = sif.limiting;
			pgs_switch u_sw (
				.clk(clk),
				.rst_b(rst_b),
				.sif(sif)
			);
		end
	endgenerate

	assign any_en = |rail_en_r;
	assign any_fault = |(mon_fault & rail_en_r);
	assign abort = !any_en || suspend || seq_powerdown || undervoltage_lockout_s;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			PGS_OFF: begin
				if (!abort && seq_done && !any_fault) begin
					state_nxt = PGS_WAIT;
				end
			end
			PGS_WAIT: begin
				if (any_fault) begin
					state_nxt = PGS_FAULT;
				end else if (abort) begin
					state_nxt = PGS_OFF;
				end else if (dly_r >= ctrl_r[`PGS_CTRL_DLY_MSB:`PGS_CTRL_DLY_LSB]) begin
					state_nxt = PGS_GOOD;
				end
			end
			PGS_GOOD: begin
				if (any_fault) begin
					state_nxt = PGS_FAULT;
				end else if (abort) begin
					state_nxt = PGS_OFF;
				end
			end
			PGS_FAULT: begin
				// held until the power-down has shut the rails
				if (!any_en) begin
					state_nxt = PGS_OFF;
				end
			end
			default: state_nxt = PGS_OFF;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= PGS_OFF;
			pg_oe_r <= 1'b1;
		end else begin
			state_r <= state_nxt;
			pg_oe_r <= (state_nxt != PGS_GOOD);
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dly_r <= '0;
		end else if (state_r != PGS_WAIT) begin
			dly_r <= '0;
		end else if (tick_ms_r && dly_r != 8'hFF) begin
			dly_r <= dly_r + 8'h01;
		end
	end

	// one-cycle request to the sequencer: rail fault or supply failure
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			undervoltage_lockout_d_r <= 1'b0;
			pd_r <= 1'b0;
		end else begin
			undervoltage_lockout_d_r <= undervoltage_lockout_s;
			pd_r <= (state_nxt == PGS_FAULT && state_r != PGS_FAULT) || (undervoltage_lockout_s && !undervoltage_lockout_d_r);
		end
	end

	// backup good never feeds the main supervisor
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bu_r <= 1'b0;
		end else begin
			bu_r <= &bu_s;
		end
	end

	// reset is the brown-out: every rail off with discharge on
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rail_dchg_r <= '1;
		end else begin
			rail_dchg_r <= ~rail_en_r;
		end
	end

	// bus slave: one wait cycle, then the answer
	assign bus_req = avs_read | avs_write;
	assign bus_wr = avs_write && !wait_r;

	always_comb begin
		rd_mux = '0;
		if (avs_address == `PGS_REG_CTRL) begin
			rd_mux = ctrl_r;
		end else if (avs_address == `PGS_REG_ENABLE) begin
			rd_mux[`PGS_EN_RAIL_MSB:`PGS_EN_RAIL_LSB] = rail_en_r;
			rd_mux[`PGS_EN_SW_MSB:`PGS_EN_SW_LSB] = sw_en_r;
		end else if (avs_address == `PGS_REG_SWCFG) begin
			rd_mux[`PGS_SW_LIM3_MSB:`PGS_SW_DCHG_LSB] = swcfg_r;
		end else if (avs_address == `PGS_REG_FLAGS) begin
			rd_mux[`PGS_FL_FAULT_MSB:`PGS_FL_ILIM_LSB] = flags_r;
			rd_mux[`PGS_ST_PG] = ~pg_oe_r;
			rd_mux[`PGS_ST_BU] = bu_r;
			rd_mux[`PGS_ST_RAIL_MSB:`PGS_ST_RAIL_LSB] = mon_fault;
			rd_mux[`PGS_ST_PIN] = pin_s;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wait_r <= 1'b1;
			rdata_r <= '0;
		end else if (bus_req && wait_r) begin
			wait_r <= 1'b0;
			rdata_r <= avs_read ? rd_mux : 32'h0000_0000;
		end else begin
			wait_r <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_r <= `PGS_CTRL_RESET;
			swcfg_r <= '0;
		end else if (bus_wr && avs_address == `PGS_REG_CTRL) begin
			ctrl_r <= '0;
			ctrl_r[`PGS_CTRL_SUPERVISION_A] <= avs_writedata[`PGS_CTRL_SUPERVISION_A];
			ctrl_r[`PGS_CTRL_DLY_MSB:`PGS_CTRL_DLY_LSB] <= avs_writedata[`PGS_CTRL_DLY_MSB:`PGS_CTRL_DLY_LSB];
		end else if (bus_wr && avs_address == `PGS_REG_SWCFG) begin
			swcfg_r <= avs_writedata[`PGS_SW_LIM3_MSB:`PGS_SW_DCHG_LSB];
		end
	end

	// rail enables: software writes, sequencer strobes on top
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rail_en_r <= '0;
		end else begin
			if (bus_wr && avs_address == `PGS_REG_ENABLE) begin
				rail_en_r <= (avs_writedata[`PGS_EN_RAIL_MSB:`PGS_EN_RAIL_LSB] | seq_rail_set) & ~seq_rail_clr;
			end else begin
				rail_en_r <= (rail_en_r | seq_rail_set) & ~seq_rail_clr;
			end
		end
	end

	// a trip is an edge: a switch re-enabled while the input stays high keeps running
	assign pf_trip = pf_s && !pf_d_r;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pf_d_r <= 1'b0;
			sw_en_r <= '0;
		end else begin
			pf_d_r <= pf_s;
			if (bus_wr && avs_address == `PGS_REG_ENABLE) begin
				sw_en_r <= avs_writedata[`PGS_EN_SW_MSB:`PGS_EN_SW_LSB];
			end else if (pf_trip) begin
				sw_en_r <= sw_en_r & ~swcfg_r[`PGS_SW_SHED_MSB:`PGS_SW_SHED_LSB];
			end else if (seq_switch1_set) begin
				sw_en_r[0] <= 1'b1;
			end else if (seq_switch1_clr) begin
				sw_en_r[0] <= 1'b0;
			end
		end
	end

	// sticky flags, write one to clear; a new event in the clear cycle wins
	always_comb begin
		flags_nxt = flags_r;
		if (bus_wr && avs_address == `PGS_REG_FLAGS) begin
			flags_nxt = flags_r & ~avs_writedata[`PGS_FL_FAULT_MSB:`PGS_FL_ILIM_LSB];
		end
		flags_nxt = flags_nxt | {sw_fault, sw_lim};
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			flags_r <= '0;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	assign avs_readdata = rdata_r;
	assign avs_waitrequest = wait_r;
	assign main_power_good_o = 1'b0;
	assign main_power_good_oe = pg_oe_r;
	assign backup_power_good = bu_r;
	assign powerdown_trigger = pd_r;
	assign rail_enable = rail_en_r;
	assign rail_discharge = rail_dchg_r;
	assign switch_enable = sw_on;
	assign switch_discharge_enable = sw_dchg;
	assign switch2_limit_select = swcfg_r[`PGS_SW_LIM2_MSB:`PGS_SW_LIM2_LSB];
	assign switch3_limit_select = swcfg_r[`PGS_SW_LIM3_MSB:`PGS_SW_LIM3_LSB];
endmodule

/* testbench/pgs_top_chk.sv */
`timescale 1ns/1ps
module pgs_top_chk #(
	parameter pgs_pkg::pgs_blank_t BLANK_US = 13'h0014,
	parameter pgs_pkg::pgs_us_t UV_RELAX_US = 10'h014
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire pgs_pkg::pgs_rail_t rail_uv,
	input wire pgs_pkg::pgs_rail_t rail_enable,
	input wire logic [1:0] backup_rail_good,
	input wire logic undervoltage_lockout,
	input wire pgs_pkg::pgs_sw_t switch_ots,
	input wire logic suspend,
	input wire logic main_power_good_oe,
	input wire logic backup_power_good,
	input wire logic powerdown_trigger,
	input wire pgs_pkg::pgs_sw_t switch_enable
);
	import pgs_pkg::*;
	// blanking plus the longer fall deglitch, 100 cycles a microsecond, with sync slack
	localparam int FLT_LIM = (int'(BLANK_US) + ((int'(UV_RELAX_US) > 50) ? int'(UV_RELAX_US) : 50) + 3) * 100;
	logic [15:0] bad_r;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bad_r <= 16'h0000;
		end else if ((rail_uv & rail_enable) == 5'h00) begin
			bad_r <= 16'h0000;
		end else if (bad_r != 16'hFFFF) begin
			bad_r <= bad_r + 16'h0001;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus request not answered next cycle");
	a_wait_short: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_trig_pulse: assert property (powerdown_trigger |=> !powerdown_trigger)
		else $error("power-down trigger longer than one cycle");
	a_undervoltage_lockout_trig: assert property ($rose(undervoltage_lockout) |-> ##[1:6] powerdown_trigger)
		else $error("lockout did not start power-down");
	a_pd_low: assert property (powerdown_trigger |-> ##[0:2] main_power_good_oe)
		else $error("power good not low on power-down");
	a_susp_low: assert property (suspend ##1 suspend |-> main_power_good_oe)
		else $error("power good not low in suspend");
	a_all_off: assert property (rail_enable == 5'h00 ##1 rail_enable == 5'h00 |-> main_power_good_oe)
		else $error("power good released with all rails off");
	a_bu_and: assert property ((backup_rail_good == 2'h3) [*5] |-> backup_power_good)
		else $error("backup good missing");
	a_bu_low: assert property ((backup_rail_good != 2'h3) [*5] |-> !backup_power_good)
		else $error("backup good with a rail bad");
	a_ots_off: assert property ($stable(switch_ots) [*4] |-> (switch_ots & switch_enable) == 3'h0)
		else $error("hot switch left on");
	a_fault_drop: assert property (bad_r >= 16'(FLT_LIM) |-> main_power_good_oe)
		else $error("power good released with a lasting rail fault");
	cover property ($fell(main_power_good_oe));
	cover property (powerdown_trigger);
	cover property (avs_read && !avs_waitrequest);
endmodule

bind pgs_top pgs_top_chk #(.BLANK_US(BLANK_US), .UV_RELAX_US(UV_RELAX_US)) u_chk (.clk, .rst_b, .avs_read,
	.avs_write, .avs_waitrequest, .rail_uv, .rail_enable, .backup_rail_good, .undervoltage_lockout, .switch_ots,
	.suspend, .main_power_good_oe, .backup_power_good, .powerdown_trigger, .switch_enable);

/* testbench/pgs_host_model.sv */
`timescale 1ns/1ps
module pgs_host_model (
	input wire logic pin_drive,
	input wire logic pin_oe,
	output logic pin_level,
	output logic host_reset_b
);
	// pull-up on the host reset line: a released pin reads high, so the host leaves reset
	assign pin_level = pin_oe ? pin_drive : 1'b1;
	assign host_reset_b = pin_level;
endmodule

/* testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import pgs_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, got;
	logic avs_waitrequest, main_power_good_i, main_power_good_o, main_power_good_oe;
	logic backup_power_good, powerdown_trigger, host_reset_b;
	logic trig_seen = 1'b0;
	pgs_rail_t rail_uv = 5'h00;
	pgs_rail_t rail_ov = 5'h00;
	pgs_rail_t seq_rail_set = 5'h00;
	pgs_rail_t seq_rail_clr = 5'h00;
	pgs_rail_t rail_enable, rail_discharge;
	logic [1:0] backup_rail_good = 2'h0;
	logic power_fail_input = 1'b0;
	logic undervoltage_lockout = 1'b0;
	logic switch2_input_uv = 1'b0;
	logic seq_done = 1'b0;
	logic seq_powerdown = 1'b0;
	logic suspend = 1'b0;
	logic seq_switch1_set = 1'b0;
	logic seq_switch1_clr = 1'b0;
	pgs_sw_t switch_ilim = 3'h0;
	pgs_sw_t switch_ots = 3'h0;
	pgs_sw_t switch_enable, switch_discharge_enable;
	pgs_lim_t switch2_limit_select, switch3_limit_select;
	logic [19:0] lfsr = 20'h1675C;
	int n_fail = 0;
	int check_count = 0;
	int k;
	// short blanking and deglitch so a full fault fits in a few thousand cycles
	pgs_top #(.BLANK_US(13'h0014), .UV_RELAX_US(10'h014), .OV_FALL_US(10'h014), .MS_TICKS(10'h005)) dut (
		.clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
		.rail_uv, .rail_ov, .backup_rail_good, .power_fail_input, .undervoltage_lockout, .switch_ilim,
		.switch_ots, .switch2_input_uv, .seq_done, .seq_powerdown, .suspend, .seq_rail_set, .seq_rail_clr,
		.seq_switch1_set, .seq_switch1_clr, .main_power_good_i, .main_power_good_o, .main_power_good_oe,
		.backup_power_good, .powerdown_trigger, .rail_enable, .rail_discharge, .switch_enable,
		.switch_discharge_enable, .switch2_limit_select, .switch3_limit_select);
	pgs_host_model host (.pin_drive(main_power_good_o), .pin_oe(main_power_good_oe),
		.pin_level(main_power_good_i), .host_reset_b);
	always #5 clk = ~clk;
	always @(posedge clk) if (powerdown_trigger === 1'b1) trig_seen <= 1'b1;
	function automatic logic [19:0] nx(logic [19:0] s);
		return {s[18:0], s[19] ^ s[16]};
	endfunction
	task report_and_stop;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
		int i;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (avs_waitrequest !== 1'b0 && i < 40);
		got = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (i >= 40) begin
			chk("bus wait", 32'h0, 32'h1);
			report_and_stop();
		end
		@(posedge clk);
	endtask
	task automatic wait_oe(logic v, int lim);
		k = 0;
		while (main_power_good_oe !== v && k < lim) begin
			@(posedge clk);
			k++;
		end
		if (k >= lim) begin
			chk("pg wait", 32'h0, 32'h1);
			report_and_stop();
		end
	endtask
	initial begin
		tick(95000);
		chk("run limit", 32'h0, 32'h1);
		report_and_stop();
	end
	initial begin
		tick(16);
		rst_b <= 1'b1;
		tick(2);
		chk("pg oe", 1, main_power_good_oe);
		chk("rail dis", 32'h1F, rail_discharge);
		bus(1'b1, 4'h2, 32'hFFFF_FFFF);
		bus(1'b0, 4'h2, 32'h0);
		chk("unmapped", 32'h0, got);
		bus(1'b0, 4'h0, 32'h0);
		chk("ctrl", 32'h0, got);
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, 4'h8, {22'h0, 2'(3 - i), 2'(i), 6'h0});
			chk("lim2", i, switch2_limit_select);
			chk("lim3", 3 - i, switch3_limit_select);
		end
		for (int i = 0; i < 8; i++) begin
			lfsr = nx(lfsr);
			backup_rail_good <= lfsr[1:0];
			tick(6);
			chk("bu", &lfsr[1:0], backup_power_good);
			chk("pg", 1, main_power_good_oe | trig_seen);
		end
		backup_rail_good <= 2'h3;
		$display("test regs and backup done");
		bus(1'b1, 4'h0, 32'h0000_0100);
		bus(1'b1, 4'h4, 32'h0000_0001);
		seq_done <= 1'b1;
		@(posedge clk);
		wait_oe(1'b0, 3000);
		chk("dly", 1, k >= 450 && k <= 650);
		tick(2);
		chk("host", 1, host_reset_b);
		bus(1'b0, 4'hC, 32'h0);
		chk("status", 32'h0100_0100, got & 32'h0100_0100);
		rail_uv <= 5'h02;
		bus(1'b1, 4'h4, 32'h0000_0003);
		tick(3000);
		chk("blank", 0, main_power_good_oe);
		rail_uv <= 5'h00;
		bus(1'b1, 4'h4, 32'h0000_0001);
		rail_uv <= 5'h02;
		tick(3000);
		chk("off rail", 0, main_power_good_oe);
		rail_uv <= 5'h01;
		tick(1500);
		rail_uv <= 5'h00;
		tick(20);
		rail_uv <= 5'h01;
		tick(1500);
		rail_uv <= 5'h00;
		rail_ov <= 5'h01;
		tick(3000);
		chk("glitch ov", 0, main_power_good_oe);
		rail_ov <= 5'h00;
		suspend <= 1'b1;
		tick(3);
		chk("susp", 1, main_power_good_oe);
		suspend <= 1'b0;
		wait_oe(1'b0, 3000);
		trig_seen <= 1'b0;
		rail_uv <= 5'h01;
		wait_oe(1'b1, 4000);
		chk("uv t", 1, k >= 1850 && k <= 2400);
		tick(5500);
		chk("trig", 1, trig_seen);
		rail_uv <= 5'h00;
		$display("test relaxed done");
		rst_b <= 1'b0;
		tick(4);
		rst_b <= 1'b1;
		tick(2);
		bus(1'b1, 4'h0, 32'h0000_0001);
		bus(1'b1, 4'h4, 32'h0000_0001);
		wait_oe(1'b0, 3000);
		bus(1'b1, 4'h4, 32'h0);
		tick(1);
		chk("last off", 1, main_power_good_oe);
		chk("host rst", 0, host_reset_b);
		bus(1'b1, 4'h4, 32'h0000_0001);
		wait_oe(1'b0, 3000);
		tick(2500);
		rail_ov <= 5'h01;
		wait_oe(1'b1, 9000);
		chk("ov t", 1, k >= 4850 && k <= 5400);
		rail_ov <= 5'h00;
		$display("test supervision_a done");
		bus(1'b1, 4'h8, 32'h0000_000F);
		bus(1'b1, 4'h4, 32'h0000_00E0);
		tick(2);
		chk("sw on", 7, switch_enable);
		chk("no dchg", 0, switch_discharge_enable);
		switch_ots <= 3'h4;
		switch2_input_uv <= 1'b1;
		switch_ilim <= 3'h1;
		tick(5);
		chk("sw held", 1, switch_enable);
		chk("dchg", 6, switch_discharge_enable);
		bus(1'b0, 4'hC, 32'h0);
		chk("flags", 32'h31, got & 32'h3F);
		bus(1'b1, 4'hC, 32'h0000_003F);
		bus(1'b0, 4'hC, 32'h0);
		chk("flag set wins", 32'h31, got & 32'h3F);
		switch_ots <= 3'h0;
		switch2_input_uv <= 1'b0;
		switch_ilim <= 3'h0;
		tick(5);
		chk("recover", 7, switch_enable);
		bus(1'b1, 4'hC, 32'h0000_003F);
		bus(1'b0, 4'hC, 32'h0);
		chk("flag clr", 0, got & 32'h3F);
		power_fail_input <= 1'b1;
		tick(5);
		power_fail_input <= 1'b0;
		tick(5);
		chk("shed", 6, switch_enable);
		seq_switch1_set <= 1'b1;
		@(posedge clk);
		seq_switch1_set <= 1'b0;
		tick(3);
		chk("seq on", 7, switch_enable);
		seq_switch1_clr <= 1'b1;
		@(posedge clk);
		seq_switch1_clr <= 1'b0;
		tick(3);
		chk("seq off", 6, switch_enable);
		$display("test switches done");
		seq_rail_set <= 5'h01;
		@(posedge clk);
		seq_rail_set <= 5'h00;
		tick(1);
		chk("seq rail", 1, rail_enable);
		wait_oe(1'b0, 3000);
		seq_powerdown <= 1'b1;
		tick(3);
		chk("pd seq", 1, main_power_good_oe);
		seq_powerdown <= 1'b0;
		wait_oe(1'b0, 3000);
		trig_seen <= 1'b0;
		undervoltage_lockout <= 1'b1;
		tick(8);
		chk("lockout", 1, trig_seen);
		chk("lockout pg", 1, main_power_good_oe);
		$display("test lockout done");
		report_and_stop();
	end
endmodule
